// ==== design/rfx_regs.sv ====
// Status flag and extension control registers of the clock module
//
// Behaviour
// - Update event sets flag bit 5; held until host writes zero.
// - Timer event sets flag bit 4; held until host writes zero.
// - Alarm event sets flag bit 3; held until host writes zero.
// - Data loss sets flag bit 1; held until zero written; one at power-up.
// - Zero write clears data-loss flag, re-arms; one ignored; host reinits.
// - Compensation stop sets flag bit 0; held until zero; one at power-up.
// - Zero write clears compensation-stop flag; one write ignored.
// - Flag bits 7, 6 and 2 ignore writes and read zero.
// - Extension test and frequency bits read zero after power-up.
// - Test bit clears on STOP, repeated START or bus timeout.
// - Bit 6 picks alarm target: one day of month, zero weekday.
// - Bit 5 picks second (500 ms release) or minute (7.813 ms) update.
// - Writing one to bit 4 starts timer from preset; zero stops it.
// - Bits 3:2 pick output: 32768, 1024, 1 or 32768 Hz.
// - Bits 1:0 pick timer source: 4096 Hz, 64 Hz, second, minute.
`timescale 1ns/1ps
module rfx_regs
    import rfx_pkg::*;
#(
    parameter int RELEASE_SEC_CYCLES = RFX_RELEASE_SEC_US * RFX_CLK_MHZ,
    parameter int RELEASE_MIN_CYCLES = RFX_RELEASE_MIN_US * RFX_CLK_MHZ
) (
    input wire logic clk,
    input wire logic resetn,
    input wire rfx_pkg::rfx_req_type req,
    input wire logic bus_stop,
    input wire logic bus_restart,
    input wire logic bus_timeout,
    input wire rfx_pkg::rfx_event_type events,
    output logic [7:0] rd_data,
    output rfx_pkg::rfx_ctrl_type ctrl,
    output logic timer_start,
    output logic [RFX_RELEASE_W-1:0] output_release_time
);
    import rfx_pkg::*;

    // Register state
    logic [7:0] ext_r;
    logic [7:0] ext_nxt;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    rfx_ctrl_type ctrl_r;
    rfx_ctrl_type ctrl_nxt;
    logic timer_start_r;
    logic timer_start_nxt;
    logic [RFX_RELEASE_W-1:0] release_r;
    logic [RFX_RELEASE_W-1:0] release_nxt;

    // Address decoding
    logic wr_ext;
    logic wr_flag;
    logic sel_ext;
    logic sel_flag;
    logic test_clear;

    // Flag vector and its set and clear terms
    logic [RFX_NUM_FLAGS-1:0] flag_vec;
    logic [RFX_NUM_FLAGS-1:0] flag_set;
    logic [RFX_NUM_FLAGS-1:0] flag_wdata;
    logic [RFX_NUM_FLAGS-1:0] flag_clr;
    logic [7:0] flag_rd;

    // Frequency output decode
    function automatic rfx_fout_type fout_decode(input logic [1:0] sel);
        rfx_fout_type f;
        f = RFX_FOUT_32768;
        case (sel)
            RFX_FSEL_32K: f = RFX_FOUT_32768;
            RFX_FSEL_1K: f = RFX_FOUT_1024;
            RFX_FSEL_1HZ: f = RFX_FOUT_1;
            RFX_FSEL_32K_B: f = RFX_FOUT_32768;
            default: f = RFX_FOUT_32768;
        endcase
        return f;
    endfunction

    // Timer source decode
    function automatic rfx_tsrc_type tsrc_decode(input logic [1:0] sel);
        rfx_tsrc_type t;
        t = RFX_SRC_4096;
        case (sel)
            RFX_TSRC_4096HZ: t = RFX_SRC_4096;
            RFX_TSRC_64HZ: t = RFX_SRC_64;
            RFX_TSRC_SECOND: t = RFX_SRC_SEC;
            RFX_TSRC_MINUTE: t = RFX_SRC_MIN;
            default: t = RFX_SRC_4096;
        endcase
        return t;
    endfunction

    // Register select from the request address
    assign sel_ext = (req.addr == RFX_ADDR_EXT);
    assign sel_flag = (req.addr == RFX_ADDR_FLAG);
    assign wr_ext = req.wr && sel_ext;
    assign wr_flag = req.wr && sel_flag;

    // Any bus end-of-transfer condition drops the test bit
    assign test_clear = bus_stop || bus_restart || bus_timeout;

    // Event pulses into the flag vector
    assign flag_set[RFX_FI_UPDATE] = events.update;
    assign flag_set[RFX_FI_TIMER] = events.timer;
    assign flag_set[RFX_FI_ALARM] = events.alarm;
    assign flag_set[RFX_FI_LOSS] = events.data_loss;
    assign flag_set[RFX_FI_COMP] = events.comp_stop;

    // Written bits mapped onto the flag vector
    assign flag_wdata[RFX_FI_UPDATE] = req.data[RFX_FLAG_UPDATE];
    assign flag_wdata[RFX_FI_TIMER] = req.data[RFX_FLAG_TIMER];
    assign flag_wdata[RFX_FI_ALARM] = req.data[RFX_FLAG_ALARM];
    assign flag_wdata[RFX_FI_LOSS] = req.data[RFX_FLAG_LOSS];
    assign flag_wdata[RFX_FI_COMP] = req.data[RFX_FLAG_COMP];

    // Only a written zero clears; a written one is ignored
    assign flag_clr = {RFX_NUM_FLAGS{wr_flag}} &
        ~flag_wdata;

    // One sticky cell per flag
    genvar gi;
    generate
        for (gi = 0; gi < RFX_NUM_FLAGS; gi++) begin : g_flag
            rfx_sticky_flag #(
                .RESET_VAL(RFX_FLAG_RESET[gi])
            ) u_flag (
                .clk(clk),
                .resetn(resetn),
                .set(flag_set[gi]),
                .clr(flag_clr[gi]),
                .flag(flag_vec[gi])
            );
        end
    endgenerate

    // Flag register read image, protected bits tied to zero
    always_comb begin
        flag_rd = 8'h00;
        flag_rd[RFX_FLAG_UPDATE] = flag_vec[RFX_FI_UPDATE];
        flag_rd[RFX_FLAG_TIMER] = flag_vec[RFX_FI_TIMER];
        flag_rd[RFX_FLAG_ALARM] = flag_vec[RFX_FI_ALARM];
        flag_rd[RFX_FLAG_LOSS] = flag_vec[RFX_FI_LOSS];
        flag_rd[RFX_FLAG_COMP] = flag_vec[RFX_FI_COMP];
    end

    // Extension register next value; end-of-transfer clear beats a write
    always_comb begin
        ext_nxt = ext_r;
        if (wr_ext) begin
            ext_nxt = req.data;
        end
        if (test_clear) begin
            ext_nxt[RFX_EXT_TEST] = 1'b0;
        end
    end

    // Read data for the addressed register; others read zero
    always_comb begin
        if (sel_ext) begin
            rd_data_nxt = ext_r;
        end else if (sel_flag) begin
            rd_data_nxt = flag_rd;
        end else begin
            rd_data_nxt = 8'h00;
        end
    end

    // Controls decoded from the extension register
    always_comb begin
        ctrl_nxt.test_mode = ext_nxt[RFX_EXT_TEST];
        ctrl_nxt.alarm_target_select = ext_nxt[RFX_EXT_ALARM_TGT];
        ctrl_nxt.update_period_select = ext_nxt[RFX_EXT_UPD_SEL];
        ctrl_nxt.timer_run_enable = ext_nxt[RFX_EXT_TIMER_EN];
        ctrl_nxt.fout = fout_decode(
            ext_nxt[RFX_EXT_FSEL_HI:RFX_EXT_FSEL_LO]);
        ctrl_nxt.tsrc = tsrc_decode(
            ext_nxt[RFX_EXT_TSEL_HI:RFX_EXT_TSEL_LO]);
    end

    // Each write of one to the enable bit reloads the preset
    assign timer_start_nxt = wr_ext && req.data[RFX_EXT_TIMER_EN];

    // Output release time follows the update period choice
    assign release_nxt = ext_nxt[RFX_EXT_UPD_SEL] ?
        RELEASE_MIN_CYCLES[RFX_RELEASE_W-1:0] :
        RELEASE_SEC_CYCLES[RFX_RELEASE_W-1:0];

    // Extension register and derived outputs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ext_r <= RFX_EXT_RESET;
            ctrl_r <= '{test_mode: 1'b0, alarm_target_select: 1'b0,
                update_period_select: 1'b0, timer_run_enable: 1'b0,
                fout: RFX_FOUT_32768, tsrc: RFX_SRC_4096};
            timer_start_r <= 1'b0;
            release_r <= RELEASE_SEC_CYCLES[RFX_RELEASE_W-1:0];
        end else begin
            ext_r <= ext_nxt;
            ctrl_r <= ctrl_nxt;
            timer_start_r <= timer_start_nxt;
            release_r <= release_nxt;
        end
    end

    // Registered read data
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign ctrl = ctrl_r;
    assign timer_start = timer_start_r;
    assign output_release_time = release_r;
endmodule

// ==== design/rfx_pkg.sv ====
// Shared constants and types for the clock flag and extension registers
package rfx_pkg;

    // Register addresses on the internal register port
    localparam logic [3:0] RFX_ADDR_EXT = 4'hd;
    localparam logic [3:0] RFX_ADDR_FLAG = 4'he;

    // Flag register bit positions
    localparam int RFX_FLAG_UPDATE = 5;
    localparam int RFX_FLAG_TIMER = 4;
    localparam int RFX_FLAG_ALARM = 3;
    localparam int RFX_FLAG_LOSS = 1;
    localparam int RFX_FLAG_COMP = 0;

    // Extension register bit positions
    localparam int RFX_EXT_TEST = 7;
    localparam int RFX_EXT_ALARM_TGT = 6;
    localparam int RFX_EXT_UPD_SEL = 5;
    localparam int RFX_EXT_TIMER_EN = 4;
    localparam int RFX_EXT_FSEL_HI = 3;
    localparam int RFX_EXT_FSEL_LO = 2;
    localparam int RFX_EXT_TSEL_HI = 1;
    localparam int RFX_EXT_TSEL_LO = 0;

    // Number of sticky flags and their index in the flag vector
    localparam int RFX_NUM_FLAGS = 5;
    localparam int RFX_FI_UPDATE = 4;
    localparam int RFX_FI_TIMER = 3;
    localparam int RFX_FI_ALARM = 2;
    localparam int RFX_FI_LOSS = 1;
    localparam int RFX_FI_COMP = 0;
    // Power-up values of the flags (update, timer, alarm, loss, comp)
    localparam logic [4:0] RFX_FLAG_RESET = 5'h03;

    // Power-up value of the extension register
    localparam logic [7:0] RFX_EXT_RESET = 8'h00;

    // Frequency output selections
    localparam logic [1:0] RFX_FSEL_32K = 2'h0;
    localparam logic [1:0] RFX_FSEL_1K = 2'h1;
    localparam logic [1:0] RFX_FSEL_1HZ = 2'h2;
    localparam logic [1:0] RFX_FSEL_32K_B = 2'h3;

    // Timer source clock selections
    localparam logic [1:0] RFX_TSRC_4096HZ = 2'h0;
    localparam logic [1:0] RFX_TSRC_64HZ = 2'h1;
    localparam logic [1:0] RFX_TSRC_SECOND = 2'h2;
    localparam logic [1:0] RFX_TSRC_MINUTE = 2'h3;

    // Clock rate and automatic output release times
    localparam int RFX_CLK_MHZ = 100;
    localparam int RFX_RELEASE_SEC_US = 500000;
    localparam int RFX_RELEASE_MIN_US = 7813;
    localparam int RFX_RELEASE_W = 26;

    // Frequency output as one-hot code
    typedef enum logic [2:0] {
        RFX_FOUT_32768 = 3'h1,
        RFX_FOUT_1024 = 3'h2,
        RFX_FOUT_1 = 3'h4
    } rfx_fout_type;

    // Timer source as one-hot code
    typedef enum logic [3:0] {
        RFX_SRC_4096 = 4'h1,
        RFX_SRC_64 = 4'h2,
        RFX_SRC_SEC = 4'h4,
        RFX_SRC_MIN = 4'h8
    } rfx_tsrc_type;

    // Event pulses from the clock engines
    typedef struct packed {
        logic update;
        logic timer;
        logic alarm;
        logic data_loss;
        logic comp_stop;
    } rfx_event_type;

    // Register port request from the serial front end
    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [7:0] data;
    } rfx_req_type;

    // Decoded control towards the clock engines
    typedef struct packed {
        logic test_mode;
        logic alarm_target_select;
        logic update_period_select;
        logic timer_run_enable;
        rfx_fout_type fout;
        rfx_tsrc_type tsrc;
    } rfx_ctrl_type;

endpackage

// ==== design/rfx_sticky_flag.sv ====
// One sticky event flag, set by hardware and cleared by a zero write
`timescale 1ns/1ps
module rfx_sticky_flag #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic set,
    input wire logic clr,
    output logic flag
);
    logic flag_r;
    logic flag_nxt;

    // Set wins over a clear in the same cycle, so no event is lost
    assign flag_nxt = set ? 1'b1 : (clr ? 1'b0 : flag_r);

    // Flag storage
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag_r <= RESET_VAL;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;
endmodule

// ==== test/rfx_regs_asserts.sv ====
// Checker for the flag and extension register port
`timescale 1ns/1ps
module rfx_regs_asserts
    import rfx_pkg::*;
#(
    parameter int RELEASE_SEC_CYCLES = 50,
    parameter int RELEASE_MIN_CYCLES = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire rfx_pkg::rfx_req_type req,
    input wire logic bus_stop,
    input wire logic bus_restart,
    input wire logic bus_timeout,
    input wire rfx_pkg::rfx_event_type events,
    input wire logic [7:0] rd_data,
    input wire rfx_pkg::rfx_ctrl_type ctrl,
    input wire logic timer_start,
    input wire logic [RFX_RELEASE_W-1:0] output_release_time
);
    import rfx_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Decoded requests and expected control values
    wire ext_wr = req.wr && req.addr == 4'hd;
    wire flag_rd = req.addr == 4'he;
    wire bus_end = bus_stop || bus_restart || bus_timeout;
    wire ts_exp = ext_wr && req.data[4];
    wire [2:0] fout_exp = req.data[3:2] == 2'h1 ? 3'h2 :
        req.data[3:2] == 2'h2 ? 3'h4 : 3'h1;
    wire [3:0] tsrc_exp = 4'h1 << req.data[1:0];
    wire [RFX_RELEASE_W-1:0] rel_exp = req.data[5] ?
        RFX_RELEASE_W'(RELEASE_MIN_CYCLES) :
        RFX_RELEASE_W'(RELEASE_SEC_CYCLES);
    rsvd_zero_a: assert property ($past(flag_rd) |->
        rd_data[7:6] == 2'h0 && !rd_data[2]) else $error("reserved bit set");
    update_set_a: assert property (events.update ##1 flag_rd |=>
        rd_data[5]) else $error("update flag not set");
    timer_set_a: assert property (events.timer ##1 flag_rd |=>
        rd_data[4]) else $error("timer flag not set");
    alarm_clear_a: assert property (req.wr && flag_rd &&
        !req.data[3] && !events.alarm ##1 flag_rd |=> !rd_data[3])
        else $error("alarm stuck");
    loss_set_a: assert property (events.data_loss ##1 flag_rd |=>
        rd_data[1]) else $error("loss flag not set");
    comp_set_a: assert property (events.comp_stop ##1 flag_rd |=>
        rd_data[0]) else $error("comp flag not set");
    test_clear_a: assert property (bus_end |=> !ctrl.test_mode)
        else $error("test bit not cleared");
    ext_fields_a: assert property (ext_wr |=>
        ctrl.alarm_target_select == $past(req.data[6]) &&
        ctrl.update_period_select == $past(req.data[5]) &&
        ctrl.timer_run_enable == $past(req.data[4])) else $error("ext field");
    fout_map_a: assert property (ext_wr |=>
        ctrl.fout == $past(fout_exp)) else $error("fout decode wrong");
    tsrc_map_a: assert property (ext_wr |=>
        ctrl.tsrc == $past(tsrc_exp)) else $error("tsrc decode wrong");
    timer_kick_a: assert property (1 |=>
        timer_start == $past(ts_exp)) else $error("timer start pulse wrong");
    release_sel_a: assert property (ext_wr |=>
        output_release_time == $past(rel_exp)) else $error("release wrong");
    cover property (ext_wr ##1 timer_start);
    cover property (events.update ##1 flag_rd);
    cover property (bus_stop ##1 !ctrl.test_mode);
endmodule

bind rfx_regs rfx_regs_asserts #(
    .RELEASE_SEC_CYCLES(RELEASE_SEC_CYCLES),
    .RELEASE_MIN_CYCLES(RELEASE_MIN_CYCLES)
) rfx_regs_asserts_inst (.clk(clk), .resetn(resetn), .req(req),
    .bus_stop(bus_stop), .bus_restart(bus_restart),
    .bus_timeout(bus_timeout), .events(events), .rd_data(rd_data),
    .ctrl(ctrl), .timer_start(timer_start),
    .output_release_time(output_release_time));

// ==== test/rfx_host_model.sv ====
// Host model that drives the register port directly, in place of the serial front end
`timescale 1ns/1ps
module rfx_host_model
    import rfx_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rd_data,
    output rfx_pkg::rfx_req_type req,
    output logic bus_stop,
    output logic bus_restart,
    output logic bus_timeout
);
    import rfx_pkg::*;
    // Idle bus at time zero
    initial begin
        req = '0;
        bus_stop = 1'b0;
        bus_restart = 1'b0;
        bus_timeout = 1'b0;
    end
    // One byte write; test bit kept zero unless the caller insists
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input bit tst);
        req.addr = a;
        req.data = (a == 4'hd && !tst) ? {1'b0, d[6:0]} : d;
        req.wr = 1'b1;
        @(posedge clk);
        #1 req.wr = 1'b0;
        req.data = ~req.data;
    endtask
    // One byte read, answer one edge later
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        req.addr = a;
        @(posedge clk);
        #1 d = rd_data;
    endtask
    // Bus end condition: 0 stop, 1 repeated start, 2 timeout
    task automatic bus_end(input int k);
        bus_stop = (k == 0);
        bus_restart = (k == 1);
        bus_timeout = (k == 2);
        @(posedge clk);
        #1 {bus_stop, bus_restart, bus_timeout} = 3'h0;
    endtask
endmodule

// ==== test/rfx_regs_tb.sv ====
// Self-checking bench for the flag and extension registers
`timescale 1ns/1ps
module rfx_regs_tb;
    import rfx_pkg::*;
    localparam int SEC_C = 50;
    localparam int MIN_C = 8;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    rfx_event_type events = '0;
    rfx_req_type req;
    logic bus_stop, bus_restart, bus_timeout, timer_start;
    logic [7:0] rd_data, got, d, e, flag_m, ext_m;
    rfx_ctrl_type ctrl;
    logic [RFX_RELEASE_W-1:0] rel, rel_x;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 32'hb376;
    always #5 clk = ~clk;
    rfx_regs #(.RELEASE_SEC_CYCLES(SEC_C), .RELEASE_MIN_CYCLES(MIN_C))
    rfx_regs_inst (.clk(clk), .resetn(resetn), .req(req),
        .bus_stop(bus_stop), .bus_restart(bus_restart),
        .bus_timeout(bus_timeout), .events(events), .rd_data(rd_data),
        .ctrl(ctrl), .timer_start(timer_start), .output_release_time(rel));
    rfx_host_model rfx_host_model_inst (.clk(clk), .rd_data(rd_data),
        .req(req), .bus_stop(bus_stop), .bus_restart(bus_restart),
        .bus_timeout(bus_timeout));
    // Compare one value against the model
    task automatic check(input logic [7:0] g, input logic [7:0] x);
        check_count++;
        if (g !== x) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // Read a register and compare
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] x);
        rfx_host_model_inst.rd(a, got);
        check(got, x);
    endtask
    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1 resetn = 1'b1;
        flag_m = 8'h03;
        ext_m = 8'h00;
        rd_chk(4'he, flag_m);
        rd_chk(4'hd, ext_m);
        rfx_host_model_inst.wr(4'he, 8'hff, 1'b1);
        rd_chk(4'he, flag_m);
        rfx_host_model_inst.wr(4'h3, 8'hff, 1'b1);
        rd_chk(4'h3, 8'h00);
        for (int i = 0; i < 60; i++) begin
            e = $random(seed);
            d = $random(seed);
            events = e[4:0];
            rfx_host_model_inst.wr(4'he, d, 1'b0);
            events = '0;
            flag_m = (flag_m & d) | {2'h0, e[4:2], 1'b0, e[1:0]};
            rd_chk(4'he, flag_m);
            d = $random(seed);
            rfx_host_model_inst.wr(4'hd, d, 1'b0);
            ext_m = {1'b0, d[6:0]};
            check({7'h0, timer_start}, {7'h0, d[4]});
            check({5'h0, ctrl.fout}, d[3:2] == 2'h1 ? 8'h2 :
                d[3:2] == 2'h2 ? 8'h4 : 8'h1);
            check({4'h0, ctrl.tsrc}, 8'h1 << d[1:0]);
            got = {5'h0, ctrl.alarm_target_select,
                ctrl.update_period_select, ctrl.timer_run_enable};
            check(got, {5'h0, d[6:4]});
            rel_x = d[5] ? RFX_RELEASE_W'(MIN_C) : RFX_RELEASE_W'(SEC_C);
            check({7'h0, rel === rel_x}, 8'h1);
            rd_chk(4'hd, ext_m);
        end
        for (int k = 0; k < 3; k++) begin
            rfx_host_model_inst.wr(4'hd, ext_m | 8'h80, 1'b1);
            check({7'h0, ctrl.test_mode}, 8'h1);
            rd_chk(4'hd, ext_m | 8'h80);
            rfx_host_model_inst.bus_end(k);
            check({7'h0, ctrl.test_mode}, 8'h0);
            rd_chk(4'hd, ext_m);
        end
        give_verdict();
    end
endmodule
